// ### verilog/dsw_regs.svh
`ifndef DSW_REGS_SVH
`define DSW_REGS_SVH

// Command word layout, sent MSB first
`define DSW_WORD_BITS 16
`define DSW_CODE_BITS 12
`define DSW_BIT_CHAN 15
`define DSW_BIT_REFBUF 14
`define DSW_BIT_DOUBLE_N 13
`define DSW_BIT_OE 12
`define DSW_CODE_MSB 11
`define DSW_CODE_LSB 0
`define DSW_CNT_BITS 5
`define DSW_CNT_FULL 5'h10
`define DSW_CNT_LAST 5'h0F

// Reset values of each channel
`define DSW_RST_CODE 12'h000
`define DSW_RST_REFBUF 1'b0
`define DSW_RST_DOUBLE_N 1'b0
`define DSW_RST_OE 1'b0

`endif

// ### verilog/dsw_pkg.sv
package dsw_pkg;
    typedef struct packed {
        logic ref_buf;
        logic double_output_n;
        logic output_enable_bit;
        logic [11:0] dac_code;
    } dsw_chan_s;

    typedef enum logic [0:0] {
        DSW_IDLE = 1'b0,
        DSW_BUSY = 1'b1
    } dsw_frame_e;

    typedef logic [15:0] dsw_word_t;
endpackage

// ### verilog/dsw_serial_port.sv
`include "dsw_regs.svh"
// Overview of operation
// - Data field is 12-bit straight binary code
// - Gain bit 1 unity, 0 double
// - Gain defaults to double
// - Per-channel reference buffer, default bypassed
// - Outputs high impedance until write and latch
// - Power-on reset holds both channels reset
// - Serial receive stays alive during shutdown
// - Active needs power-down pin high and enable
// - Power-down pin only on dual variant
// - Sample data on rising serial clock edge
// - No serial output or readback path
// - Sixteen bits MSB first, config then data
// - Select rise latches word into input register
// - Latch strobe low copies input to output
// - Clocks past sixteenth are ignored
// - No shifting while select is high
// - Short frame aborts, input registers unchanged
// - Bit 15 selects channel B or A
// - Bit 14 selects buffered reference
// - Bit 12 enables output, else high impedance
// - Bits 11 to 0 are the code
// - Serial functions only while select low
// - Strobe tied low updates at select rise
// - Power-down pin low puts both in standby
module dsw_serial_port #(
    parameter bit DUAL = 1'b1
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic output_latch_strobe_n_i,
    input wire logic power_down_n_i,
    output logic [11:0] dac_code_a_o,
    output logic [11:0] dac_code_b_o,
    output logic [1:0] ref_buffered_o,
    output logic [1:0] double_output_n_o,
    output logic [1:0] output_active_o,
    output logic low_power_o
);
    import dsw_pkg::*;

    // Link side, clocked by the serial clock
    logic frame_rst;
    logic [`DSW_CNT_BITS-1:0] cnt_reg;
    dsw_word_t shift_reg;
    dsw_word_t word_reg;
    logic tog_reg;

    // Counter cleared while select is high, so stray clocks do nothing
    assign frame_rst = rst_i | cs_n_i;

    always_ff @(posedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_reg <= '0;
        end else if (cnt_reg != `DSW_CNT_FULL) begin
            cnt_reg <= cnt_reg + `DSW_CNT_BITS'(1);
        end
    end

    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            shift_reg <= '0;
        end else if (!cs_n_i && cnt_reg != `DSW_CNT_FULL) begin
            shift_reg <= {shift_reg[`DSW_WORD_BITS-2:0], sdi_i};
        end
    end

    // Word held stable until the next full frame; toggle flags it
    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            word_reg <= '0;
            tog_reg <= 1'b0;
        end else if (!cs_n_i && cnt_reg == `DSW_CNT_LAST) begin
            word_reg <= {shift_reg[`DSW_WORD_BITS-2:0], sdi_i};
            tog_reg <= ~tog_reg;
        end
    end

    // System side synchronisers
    logic [1:0] cs_sync_reg;
    logic [2:0] tog_sync_reg;
    logic [1:0] output_latch_strobe_n_sync_reg;
    logic [1:0] pd_sync_reg;
    logic cs_s;
    logic output_latch_strobe_n_s;
    logic pd_s;
    logic tog_edge;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_sync_reg <= 2'h3;
            tog_sync_reg <= 3'h0;
            output_latch_strobe_n_sync_reg <= 2'h3;
            pd_sync_reg <= 2'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], cs_n_i};
            tog_sync_reg <= {tog_sync_reg[1:0], tog_reg};
            output_latch_strobe_n_sync_reg <= {output_latch_strobe_n_sync_reg[0], output_latch_strobe_n_i};
            pd_sync_reg <= {pd_sync_reg[0], power_down_n_i};
        end
    end

    assign cs_s = cs_sync_reg[1];
    assign output_latch_strobe_n_s = output_latch_strobe_n_sync_reg[1];
    // Single variant has no pin, so hardware shutdown never applies
    assign pd_s = DUAL ? pd_sync_reg[1] : 1'b1;
    assign tog_edge = tog_sync_reg[2] ^ tog_sync_reg[1];

    // Frame tracking; the toggle lands well before select rises
    dsw_frame_e state_reg;
    dsw_frame_e state_next;
    logic got_reg;
    logic commit;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DSW_IDLE: begin
                if (!cs_s) begin
                    state_next = DSW_BUSY;
                end
            end
            DSW_BUSY: begin
                if (cs_s) begin
                    state_next = DSW_IDLE;
                end
            end
            default: begin
                state_next = DSW_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= DSW_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            got_reg <= 1'b0;
        end else if (state_reg == DSW_IDLE) begin
            got_reg <= 1'b0;
        end else if (tog_edge) begin
            got_reg <= 1'b1;
        end
    end

    // Short frame: no toggle seen, nothing is committed
    assign commit = (state_reg == DSW_BUSY) && cs_s && (got_reg || tog_edge);

    // Per-channel input and output registers
    dsw_chan_s in_reg [2];
    dsw_chan_s out_reg [2];
    dsw_chan_s rst_chan;
    dsw_chan_s word_chan;
    logic sel_b;

    assign rst_chan = '{`DSW_RST_REFBUF, `DSW_RST_DOUBLE_N, `DSW_RST_OE, `DSW_RST_CODE};
    assign word_chan = '{word_reg[`DSW_BIT_REFBUF],
                         word_reg[`DSW_BIT_DOUBLE_N],
                         word_reg[`DSW_BIT_OE],
                         word_reg[`DSW_CODE_MSB:`DSW_CODE_LSB]};
    assign sel_b = word_reg[`DSW_BIT_CHAN];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    in_reg[ch] <= rst_chan;
                end else if (commit && (sel_b == 1'(ch)) && (DUAL || ch == 0)) begin
                    in_reg[ch] <= word_chan;
                end
            end

            // Level latch: a tied-low strobe passes each word just after commit
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    out_reg[ch] <= rst_chan;
                end else if (!output_latch_strobe_n_s) begin
                    out_reg[ch] <= in_reg[ch];
                end
            end

            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    output_active_o[ch] <= 1'b0;
                    ref_buffered_o[ch] <= `DSW_RST_REFBUF;
                    double_output_n_o[ch] <= `DSW_RST_DOUBLE_N;
                end else begin
                    output_active_o[ch] <= out_reg[ch].output_enable_bit && pd_s;
                    ref_buffered_o[ch] <= out_reg[ch].ref_buf;
                    double_output_n_o[ch] <= out_reg[ch].double_output_n;
                end
            end
        end
    endgenerate

    // Serial side never waits on shutdown state
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dac_code_a_o <= `DSW_RST_CODE;
            dac_code_b_o <= `DSW_RST_CODE;
            low_power_o <= 1'b1;
        end else begin
            dac_code_a_o <= out_reg[0].dac_code;
            dac_code_b_o <= out_reg[1].dac_code;
            low_power_o <= !pd_s;
        end
    end

    // Checks
    a_cnt_limit: assert property (@(posedge sck_i) disable iff (frame_rst)
        cnt_reg <= `DSW_CNT_FULL)
        else $error("bit count passed sixteen");

    a_latch_copy: assert property (@(posedge mclk_i) disable iff (rst_i)
        !output_latch_strobe_n_s |=> out_reg[0] == $past(in_reg[0]) && out_reg[1] == $past(in_reg[1]))
        else $error("strobe low did not copy input registers");

    a_hold_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
        output_latch_strobe_n_s |=> $stable(out_reg[0]) && $stable(out_reg[1]))
        else $error("output register changed with strobe high");

    a_abort_short: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_reg == DSW_BUSY && cs_s && !got_reg && !tog_edge)
        |=> $stable(in_reg[0]) && $stable(in_reg[1]))
        else $error("short frame altered input registers");

    a_route_b: assert property (@(posedge mclk_i) disable iff (rst_i)
        (commit && sel_b && DUAL) |=> in_reg[1] == $past(word_chan) && $stable(in_reg[0]))
        else $error("channel B write misrouted");

    a_route_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (commit && !sel_b) |=> in_reg[0].dac_code == $past(word_reg[11:0])
            && in_reg[0].ref_buf == $past(word_reg[14]))
        else $error("channel A write misrouted");

    a_active_cause: assert property (@(posedge mclk_i) disable iff (rst_i)
        output_active_o[0] |-> $past(pd_s) && $past(out_reg[0].output_enable_bit))
        else $error("channel A active without enable and pin");

    a_standby_pin: assert property (@(posedge mclk_i) disable iff (rst_i)
        !pd_s |=> low_power_o && !output_active_o[0] && !output_active_o[1])
        else $error("power-down pin low did not stand by");

    a_tied_strobe: assert property (@(posedge mclk_i) disable iff (rst_i)
        (commit && !sel_b) ##1 !output_latch_strobe_n_s |=> out_reg[0] == $past(in_reg[0]))
        else $error("tied strobe did not pass word");

    c_write_b: cover property (@(posedge mclk_i) disable iff (rst_i)
        commit && sel_b);
    c_abort: cover property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == DSW_BUSY && cs_s && !got_reg && !tog_edge);
    c_go_active: cover property (@(posedge mclk_i) disable iff (rst_i)
        !output_active_o[0] ##1 output_active_o[0]);
    c_both_active: cover property (@(posedge mclk_i) disable iff (rst_i)
        output_active_o == 2'h3);
    c_long_frame: cover property (@(posedge sck_i) disable iff (frame_rst)
        cnt_reg == `DSW_CNT_FULL);

    // Output stage follows the output registers one edge later
    a_code_a_out: assert property (@(posedge mclk_i) disable iff (rst_i)
        1'b1 |-> dac_code_a_o == $past(out_reg[0].dac_code))
        else $error("channel A code output does not follow latch");

    a_code_b_out: assert property (@(posedge mclk_i) disable iff (rst_i)
        1'b1 |-> dac_code_b_o == $past(out_reg[1].dac_code))
        else $error("channel B code output does not follow latch");

    a_gain_out: assert property (@(posedge mclk_i) disable iff (rst_i)
        1'b1 |-> double_output_n_o
            == {$past(out_reg[1].double_output_n), $past(out_reg[0].double_output_n)})
        else $error("gain outputs do not follow latch");

    a_refbuf_out: assert property (@(posedge mclk_i) disable iff (rst_i)
        1'b1 |-> ref_buffered_o == {$past(out_reg[1].ref_buf), $past(out_reg[0].ref_buf)})
        else $error("reference buffer outputs do not follow latch");

    a_standby_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
        1'b1 |-> low_power_o == !$past(pd_s))
        else $error("standby flag does not follow pin");

    a_standby_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
        low_power_o |-> !output_active_o[0] && !output_active_o[1])
        else $error("output active during standby");

    a_enable_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !out_reg[0].output_enable_bit |=> !output_active_o[0])
        else $error("channel A active with enable bit clear");

    a_enable_off_b: assert property (@(posedge mclk_i) disable iff (rst_i)
        !out_reg[1].output_enable_bit |=> !output_active_o[1])
        else $error("channel B active with enable bit clear");

    a_active_on: assert property (@(posedge mclk_i) disable iff (rst_i)
        out_reg[0].output_enable_bit && pd_s |=> output_active_o[0])
        else $error("channel A did not leave shutdown");

    a_commit_once: assert property (@(posedge mclk_i) disable iff (rst_i)
        commit |=> !commit)
        else $error("one frame committed twice");

    a_in_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        !commit |=> $stable(in_reg[0]) && $stable(in_reg[1]))
        else $error("input register changed without a frame");

    a_idle_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == DSW_IDLE |=> !got_reg)
        else $error("stale frame flag outlived select");

    a_route_a_cfg: assert property (@(posedge mclk_i) disable iff (rst_i)
        (commit && !sel_b) |=> in_reg[0].double_output_n == $past(word_reg[`DSW_BIT_DOUBLE_N])
            && in_reg[0].output_enable_bit == $past(word_reg[`DSW_BIT_OE]))
        else $error("channel A config bits misrouted");

    // Word must not move while the system side is reading it
    a_word_stable: assert property (@(posedge mclk_i) disable iff (rst_i)
        got_reg |=> $stable(word_reg))
        else $error("captured word changed during commit");

    // Link side checks run on the serial clock
    a_cs_high_cnt: assert property (@(posedge sck_i) disable iff (rst_i)
        cs_n_i |-> cnt_reg == '0)
        else $error("bit count moved with select high");

    a_cs_high_shift: assert property (@(posedge sck_i) disable iff (rst_i)
        cs_n_i |=> $stable(shift_reg))
        else $error("data shifted with select high");

    a_stop_sixteen: assert property (@(posedge sck_i) disable iff (frame_rst)
        cnt_reg == `DSW_CNT_FULL |=> $stable(shift_reg) && $stable(tog_reg))
        else $error("clock past sixteen was used");

    a_word_capture: assert property (@(posedge sck_i) disable iff (rst_i)
        (!cs_n_i && cnt_reg == `DSW_CNT_LAST)
        |=> word_reg == $past({shift_reg[`DSW_WORD_BITS-2:0], sdi_i}))
        else $error("sixteenth bit did not complete the word");
endmodule

// ### dv/dsw_host_model.sv
module dsw_host_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // Idle level of sck picks mode 0,0 or 1,1; sel low leaves select high
    task automatic send(input logic [15:0] w, input int n, input bit mode11, input bit sel);
        sck_o = mode11;
        #6;
        cs_n_o = ~sel;
        #6;
        for (int i = 0; i < n; i++) begin
            if (mode11) sck_o = 1'b0;
            // Bits past sixteen are inverted so that keeping them would show
            sdi_o = w[15 - (i % 16)] ^ (i >= 16);
            #6;
            sck_o = 1'b1;
            #6;
            if (!mode11) sck_o = 1'b0;
        end
        // Long hold so the select rise crosses to the system clock
        #100;
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #100;
    endtask
endmodule

// ### dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dsw_pkg::*;

    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic strobe_n = 1'b1;
    logic pd_n = 1'b1;
    logic sck, cs_n, sdi;
    logic [11:0] code_a, code_b;
    logic [1:0] ref_buf, dbl_n, active;
    logic low_power;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    dsw_host_model host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi));

    dsw_serial_port dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .sdi_i(sdi),
        .output_latch_strobe_n_i(strobe_n), .power_down_n_i(pd_n),
        .dac_code_a_o(code_a), .dac_code_b_o(code_b), .ref_buffered_o(ref_buf),
        .double_output_n_o(dbl_n), .output_active_o(active), .low_power_o(low_power)
    );

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    task automatic close_out();
        $display("Mismatches %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run needs about 260 cycles
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end

    function automatic logic [30:0] outs();
        return {code_a, code_b, ref_buf, dbl_n, active, low_power};
    endfunction

    task automatic chk(input string what, input logic [30:0] seen, input logic [30:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Outputs lag the pins by a few synchroniser stages
    task automatic settle();
        repeat (10) @(negedge mclk_i);
    endtask

    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        settle();
        chk("reset", outs(), {12'h000, 12'h000, 2'b00, 2'b00, 2'b00, 1'b0});
        host.send(16'h7ABC, 16, 1'b0, 1'b1);
        settle();
        chk("held", outs(), {12'h000, 12'h000, 2'b00, 2'b00, 2'b00, 1'b0});
        @(posedge mclk_i) strobe_n <= 1'b0;
        settle();
        chk("latch a", outs(), {12'hABC, 12'h000, 2'b01, 2'b01, 2'b01, 1'b0});
        host.send(16'h9FFF, 16, 1'b1, 1'b1);
        settle();
        chk("mode11 b", outs(), {12'hABC, 12'hFFF, 2'b01, 2'b01, 2'b11, 1'b0});
        host.send(16'h0123, 15, 1'b0, 1'b1);
        host.send(16'h8456, 16, 1'b0, 1'b0);
        settle();
        chk("ignored", outs(), {12'hABC, 12'hFFF, 2'b01, 2'b01, 2'b11, 1'b0});
        host.send(16'h1555, 20, 1'b0, 1'b1);
        settle();
        chk("long", outs(), {12'h555, 12'hFFF, 2'b00, 2'b00, 2'b11, 1'b0});
        @(posedge mclk_i) pd_n <= 1'b0;
        settle();
        chk("standby", outs(), {12'h555, 12'hFFF, 2'b00, 2'b00, 2'b00, 1'b1});
        host.send(16'hB321, 16, 1'b1, 1'b1);
        settle();
        chk("sd write", outs(), {12'h555, 12'h321, 2'b00, 2'b10, 2'b00, 1'b1});
        @(posedge mclk_i) pd_n <= 1'b1;
        settle();
        chk("wake", outs(), {12'h555, 12'h321, 2'b00, 2'b10, 2'b11, 1'b0});
        host.send(16'h00FF, 16, 1'b0, 1'b1);
        settle();
        chk("disable", outs(), {12'h0FF, 12'h321, 2'b00, 2'b10, 2'b10, 1'b0});
        @(posedge mclk_i) rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        settle();
        chk("rereset", outs(), {12'h000, 12'h000, 2'b00, 2'b00, 2'b00, 1'b0});
        close_out();
    end
endmodule
